// file: rtl/bgc_pkg.sv
// Register layout, reset values and shared types of the bridge control slice
package bgc_pkg;

    localparam int BGC_AW = 7;
    localparam int BGC_DW = 16;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [6:0] BGC_ADDR_MASK = 7'h09;
    localparam logic [6:0] BGC_ADDR_SCRATCH = 7'h0a;
    localparam logic [6:0] BGC_ADDR_BRIDGE_GENERAL_CONTROL = 7'h10;

    // ----------------------------------------------------------------
    // Reset values and writable-bit maps
    // ----------------------------------------------------------------
    localparam logic [15:0] BGC_MASK_RST = 16'h0140;
    localparam logic [15:0] BGC_MASK_WMASK = 16'h01ff;
    localparam logic [15:0] BGC_SCRATCH_RST = 16'h0000;
    localparam logic [15:0] BGC_GEN_RST = 16'h0801;
    localparam logic [15:0] BGC_GEN_WMASK = 16'h9fff;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BGC_MASK_SUPPLY_BIT = 0;
    localparam int BGC_MASK_TEMP_BIT = 1;
    localparam int BGC_MASK_RO_LSB = 9;
    localparam int BGC_GEN_PCHG_BIT = 8;
    localparam int BGC_GEN_OVREC_BIT = 9;
    localparam int BGC_GEN_CPSTG_BIT = 10;
    localparam int BGC_GEN_FETLVL_BIT = 11;
    localparam int BGC_GEN_CPUV_BIT = 12;
    localparam int BGC_GEN_FREQ_BIT = 15;

    typedef enum logic [1:0] {
        BGC_MODE_NORMAL,
        BGC_MODE_FAILSAFE,
        BGC_MODE_RESTART,
        BGC_MODE_OTHER
    } bgc_mode_t;

    // Register access request from the serial frame decoder
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [6:0] addr;
        logic [15:0] wdata;
    } bgc_req_t;

    // Status events, one-cycle pulses
    typedef struct packed {
        logic supply_set;
        logic temp_set;
    } bgc_evt_t;

    // Decoded bridge control outputs
    typedef struct packed {
        logic bridge_sync_freq_select;
        logic pump_undervolt_threshold_select;
        logic mosfet_level_select;
        logic pump_stage_auto_switch;
        logic bridge_overvolt_recover;
        logic precharge_step_adapt;
    } bgc_ctl_t;

endpackage

// file: rtl/bgc_regs.sv
// Interrupt mask, scratch store and bridge general control registers
//
// Summary of operation
// RULE1 - Unmasked temperature flag set pulses the interrupt output once.
// RULE2 - Unmasked supply flag set pulses the interrupt output once.
// RULE3 - Power-on or soft reset loads mask with 0x0140.
// RULE4 - Restart reset clears mask bits 15..9, keeps bits 8..0.
// RULE5 - Sixteen-bit read/write scratch register for the microcontroller.
// RULE6 - Scratch clears to zero at power-up and soft reset.
// RULE7 - Scratch reachable only in Normal Mode.
// RULE8 - Scratch survives Fail-Safe and Restart Mode entry.
// RULE9 - Only serial writes change scratch; internal logic never touches it.
// RULE10 - Control bit 15 selects bridge sync frequency, default low.
// RULE11 - Control bits 14 and 13 are read-only zero.
// RULE12 - Control bit 12 selects pump undervoltage threshold, default low.
// RULE13 - Control bit 10 enables pump stage auto switching, default off.
// RULE14 - Control bit 9 enables overvoltage auto recovery, default off.
// RULE15 - Control bit 8 selects precharge adaptation step, default one step.
// RULE16 - Every unmasked event pulses interrupt, even if status already set.
// RULE17 - Writes to read-only bits ignored, they keep reading zero.
`timescale 1ns/10ps
`default_nettype none

module bgc_regs
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic restart_reset,
    input wire bgc_pkg::bgc_mode_t mode,
    input wire bgc_pkg::bgc_req_t req,
    input wire bgc_pkg::bgc_evt_t evt,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic interrupt_out_n,
    output bgc_pkg::bgc_ctl_t ctl
);
    import bgc_pkg::*;

    typedef struct packed {
        logic [15:0] mask;
        logic [15:0] scratch;
        logic [15:0] gen;
        logic [15:0] rdata;
        logic rvalid;
        logic irq_n;
    } bgc_state_t;

    bgc_state_t st_q;
    bgc_state_t st_d;
    logic scratch_open;
    logic wr_mask;
    logic wr_scratch;
    logic wr_gen;
    logic irq_event;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign scratch_open = (mode == BGC_MODE_NORMAL); // RULE7
    assign wr_mask = req.wr_en && (req.addr == BGC_ADDR_MASK);
    assign wr_scratch = req.wr_en && (req.addr == BGC_ADDR_SCRATCH) && scratch_open; // RULE7
    assign wr_gen = req.wr_en && (req.addr == BGC_ADDR_BRIDGE_GENERAL_CONTROL);
    // Raw event pulses, so a flag already set still fires again
    assign irq_event = (evt.temp_set && st_q.mask[BGC_MASK_TEMP_BIT]) // RULE1 RULE16
        || (evt.supply_set && st_q.mask[BGC_MASK_SUPPLY_BIT]); // RULE2 RULE16

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.irq_n = !irq_event; // RULE1 RULE2
        st_d.rvalid = req.rd_en;
        if (req.rd_en)
        begin
            case (req.addr)
                BGC_ADDR_MASK: st_d.rdata = st_q.mask;
                BGC_ADDR_SCRATCH: st_d.rdata = scratch_open ? st_q.scratch : 16'h0000; // RULE7
                BGC_ADDR_BRIDGE_GENERAL_CONTROL: st_d.rdata = st_q.gen; // RULE11
                default: st_d.rdata = 16'h0000;
            endcase
        end
        // Mask: soft reset over restart over write
        if (soft_reset)
        begin
            st_d.mask = BGC_MASK_RST; // RULE3
        end
        else if (restart_reset)
        begin
            st_d.mask = st_q.mask & BGC_MASK_WMASK; // RULE4
        end
        else if (wr_mask)
        begin
            st_d.mask = req.wdata & BGC_MASK_WMASK; // RULE17
        end
        // Scratch: no internal source; restart and mode changes leave it
        if (soft_reset)
        begin
            st_d.scratch = BGC_SCRATCH_RST; // RULE6
        end
        else if (wr_scratch)
        begin
            st_d.scratch = req.wdata; // RULE5 RULE8 RULE9
        end
        // General control: restart keeps contents
        if (soft_reset)
        begin
            st_d.gen = BGC_GEN_RST; // RULE10 RULE12 RULE13 RULE14 RULE15
        end
        else if (wr_gen && !restart_reset)
        begin
            st_d.gen = req.wdata & BGC_GEN_WMASK; // RULE11 RULE17
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q.mask <= BGC_MASK_RST; // RULE3
            st_q.scratch <= BGC_SCRATCH_RST; // RULE6
            st_q.gen <= BGC_GEN_RST;
            st_q.rdata <= 16'h0000;
            st_q.rvalid <= 1'b0;
            st_q.irq_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata = st_q.rdata;
    assign rvalid = st_q.rvalid;
    assign interrupt_out_n = st_q.irq_n;
    assign ctl.bridge_sync_freq_select = st_q.gen[BGC_GEN_FREQ_BIT]; // RULE10
    assign ctl.pump_undervolt_threshold_select = st_q.gen[BGC_GEN_CPUV_BIT]; // RULE12
    assign ctl.mosfet_level_select = st_q.gen[BGC_GEN_FETLVL_BIT];
    assign ctl.pump_stage_auto_switch = st_q.gen[BGC_GEN_CPSTG_BIT]; // RULE13
    assign ctl.bridge_overvolt_recover = st_q.gen[BGC_GEN_OVREC_BIT]; // RULE14
    assign ctl.precharge_step_adapt = st_q.gen[BGC_GEN_PCHG_BIT]; // RULE15

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_temp_irq_pulse: assert property ( // RULE1
        evt.temp_set && st_q.mask[BGC_MASK_TEMP_BIT] |=> !interrupt_out_n)
        else $error("temperature event did not pulse interrupt");

    chk_supply_irq_pulse: assert property ( // RULE2
        evt.supply_set && st_q.mask[BGC_MASK_SUPPLY_BIT] |=> !interrupt_out_n)
        else $error("supply event did not pulse interrupt");

    chk_masked_no_irq: assert property ( // RULE1
        !(evt.temp_set && st_q.mask[1]) && !(evt.supply_set && st_q.mask[0]) |=> interrupt_out_n)
        else $error("interrupt without unmasked event");

    chk_repeat_irq_pulse: assert property ( // RULE16
        (evt.temp_set && st_q.mask[1])[*2] |=> !interrupt_out_n && $past(!interrupt_out_n))
        else $error("back to back events lost a pulse");

    chk_mask_soft_value: assert property ( // RULE3
        soft_reset |=> st_q.mask == 16'h0140)
        else $error("mask wrong after soft reset");

    chk_mask_restart_keep: assert property ( // RULE4
        restart_reset && !soft_reset |=> st_q.mask[15:9] == 7'h00 && $stable(st_q.mask[8:0]))
        else $error("mask wrong after restart");

    chk_scratch_soft_clear: assert property ( // RULE6
        soft_reset |=> st_q.scratch == 16'h0000)
        else $error("scratch not cleared by soft reset");

    chk_scratch_mode_lock: assert property ( // RULE7
        mode != BGC_MODE_NORMAL && !soft_reset |=> $stable(st_q.scratch))
        else $error("scratch changed outside normal mode");

    chk_scratch_write_only: assert property ( // RULE9
        !(req.wr_en && req.addr == BGC_ADDR_SCRATCH) && !soft_reset |=> $stable(st_q.scratch))
        else $error("scratch changed without a write");

    chk_scratch_roundtrip: assert property ( // RULE5
        wr_scratch && !soft_reset ##1 req.rd_en && req.addr == BGC_ADDR_SCRATCH && scratch_open
        |=> rdata == $past(req.wdata, 2))
        else $error("scratch read back differs");

    chk_gen_reserved_zero: assert property ( // RULE11
        rvalid && $past(req.addr) == BGC_ADDR_BRIDGE_GENERAL_CONTROL |-> rdata[14:13] == 2'b00)
        else $error("reserved control bits read nonzero");

    chk_mask_ro_write: assert property ( // RULE17
        wr_mask |=> st_q.mask[15:9] == 7'h00)
        else $error("read-only mask bits took a write");

    chk_gen_soft_default: assert property ( // RULE10
        soft_reset |=> !ctl.bridge_sync_freq_select && !ctl.pump_stage_auto_switch
            && !ctl.bridge_overvolt_recover && !ctl.precharge_step_adapt)
        else $error("control defaults wrong after soft reset");

    chk_temp_masked_quiet: assert property ( // RULE1
        evt.temp_set && !evt.supply_set && !st_q.mask[BGC_MASK_TEMP_BIT] |=> interrupt_out_n)
        else $error("masked temperature event pulsed interrupt");

    chk_supply_masked_quiet: assert property ( // RULE2
        evt.supply_set && !evt.temp_set && !st_q.mask[BGC_MASK_SUPPLY_BIT] |=> interrupt_out_n)
        else $error("masked supply event pulsed interrupt");

    chk_both_events_merge: assert property ( // RULE16
        evt.temp_set && evt.supply_set && st_q.mask[1:0] == 2'b11 |=> !interrupt_out_n)
        else $error("simultaneous events gave no pulse");

    chk_mask_write_lands: assert property ( // RULE17
        wr_mask && !soft_reset && !restart_reset |=> st_q.mask == ($past(req.wdata) & BGC_MASK_WMASK))
        else $error("mask write did not land");

    chk_mask_reserved_read: assert property ( // RULE17
        req.rd_en && req.addr == BGC_ADDR_MASK |=> rdata[15:9] == 7'h00)
        else $error("reserved mask bits read nonzero");

    chk_scratch_write_lands: assert property ( // RULE5
        wr_scratch && !soft_reset |=> st_q.scratch == $past(req.wdata))
        else $error("scratch write did not land");

    chk_scratch_read_open: assert property ( // RULE5
        req.rd_en && req.addr == BGC_ADDR_SCRATCH && scratch_open |=> rdata == $past(st_q.scratch))
        else $error("scratch read data wrong");

    chk_scratch_read_locked: assert property ( // RULE7
        req.rd_en && req.addr == BGC_ADDR_SCRATCH && !scratch_open |=> rdata == 16'h0000)
        else $error("scratch readable outside normal mode");

    chk_scratch_write_refused: assert property ( // RULE7
        req.wr_en && req.addr == BGC_ADDR_SCRATCH && !scratch_open && !soft_reset |=> $stable(st_q.scratch))
        else $error("scratch written outside normal mode");

    chk_scratch_restart_keep: assert property ( // RULE8
        restart_reset && !soft_reset && !wr_scratch |=> $stable(st_q.scratch))
        else $error("scratch changed by restart");

    chk_scratch_mode_keep: assert property ( // RULE8
        $changed(mode) && !soft_reset && !wr_scratch |=> $stable(st_q.scratch))
        else $error("scratch changed by mode change");

    chk_freq_follows_write: assert property ( // RULE10
        wr_gen && !soft_reset && !restart_reset
        |=> ctl.bridge_sync_freq_select == $past(req.wdata[BGC_GEN_FREQ_BIT]))
        else $error("sync frequency select did not follow write");

    chk_cpuv_follows_write: assert property ( // RULE12
        wr_gen && !soft_reset && !restart_reset
        |=> ctl.pump_undervolt_threshold_select == $past(req.wdata[BGC_GEN_CPUV_BIT]))
        else $error("undervoltage threshold select did not follow write");

    chk_cpstg_follows_write: assert property ( // RULE13
        wr_gen && !soft_reset && !restart_reset
        |=> ctl.pump_stage_auto_switch == $past(req.wdata[BGC_GEN_CPSTG_BIT]))
        else $error("pump stage auto switch did not follow write");

    chk_ovrec_follows_write: assert property ( // RULE14
        wr_gen && !soft_reset && !restart_reset
        |=> ctl.bridge_overvolt_recover == $past(req.wdata[BGC_GEN_OVREC_BIT]))
        else $error("overvoltage recover did not follow write");

    chk_pchg_follows_write: assert property ( // RULE15
        wr_gen && !soft_reset && !restart_reset
        |=> ctl.precharge_step_adapt == $past(req.wdata[BGC_GEN_PCHG_BIT]))
        else $error("precharge step select did not follow write");

    chk_cpuv_soft_default: assert property ( // RULE12
        soft_reset |=> !ctl.pump_undervolt_threshold_select)
        else $error("undervoltage threshold default wrong after soft reset");

    chk_gen_reserved_hold: assert property ( // RULE11
        st_q.gen[14:13] == 2'b00)
        else $error("reserved control bits hold nonzero");

    chk_gen_write_lands: assert property ( // RULE17
        wr_gen && !soft_reset && !restart_reset |=> st_q.gen == ($past(req.wdata) & BGC_GEN_WMASK))
        else $error("control write did not land");

    chk_rvalid_follows_read: assert property ( // RULE5
        req.rd_en |=> rvalid)
        else $error("read gave no valid pulse");

    chk_rvalid_idle: assert property ( // RULE5
        !req.rd_en |=> !rvalid)
        else $error("valid pulse without read");

    // ----------------------------------------------------------------
    // Covers
    // ----------------------------------------------------------------
    cov_temp_irq: cover property (evt.temp_set && st_q.mask[1] ##1 !interrupt_out_n);
    cov_scratch_locked: cover property (req.wr_en && req.addr == BGC_ADDR_SCRATCH && !scratch_open);
    cov_restart_mask: cover property (restart_reset && st_q.mask[8]);
    cov_freq_high: cover property (ctl.bridge_sync_freq_select);
    cov_repeat_temp: cover property ((evt.temp_set && st_q.mask[1])[*2]);

endmodule

`default_nettype wire

// file: test/bgc_host.sv
// Microcontroller model issuing register accesses over the frame decoder port
`timescale 1ns/10ps
`default_nettype none

module bgc_host
(
    input wire logic clk,
    output var bgc_pkg::bgc_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    import bgc_pkg::*;

    initial req = '0;

    // Caller keeps scratch accesses to normal mode unless a refusal is wanted
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask

    // Write followed by a read in the very next cycle
    task automatic wrrd(input logic [6:0] a, input logic [15:0] dw, output logic [15:0] d, output logic v);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, dw};
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, 16'hffff};
        #1;
        d = rdata;
        v = rvalid;
    endtask

    // Released address and data lines show the inverse pattern
    task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        req <= '{1'b0, 1'b0, ~a, 16'hffff};
        #1;
        d = rdata;
        v = rvalid;
    endtask
endmodule

`default_nettype wire

// file: test/tb_bridge_ctrl_and_irq_mask_regs.sv
// Self-checking bench of the bridge control and interrupt mask registers
`timescale 1ns/10ps
`default_nettype none

module tb_bridge_ctrl_and_irq_mask_regs;
    import bgc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_reset = 1'b0;
    logic restart_reset = 1'b0;
    bgc_mode_t mode = BGC_MODE_NORMAL;
    bgc_req_t req;
    bgc_evt_t evt = '0;
    logic [15:0] rdata;
    logic rvalid;
    logic interrupt_out_n;
    bgc_ctl_t ctl;
    int n_errors = 0;
    int n_tests = 0;
    logic [15:0] d;
    logic [15:0] sv;
    logic [1:0] m;
    logic [1:0] e;
    logic [15:0] rb;
    logic vb;
    int i;

    initial forever #5 clk = ~clk;

    bgc_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

    bgc_regs dut (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .restart_reset(restart_reset),
        .mode(mode), .req(req), .evt(evt), .rdata(rdata), .rvalid(rvalid),
        .interrupt_out_n(interrupt_out_n), .ctl(ctl));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] r;
        logic v;
        host.rd(a, r, v);
        chk({15'h0000, v}, 16'h0001);
        chk(r, exp);
    endtask

    function automatic logic [15:0] exp_ctl(input logic [15:0] g);
        return {10'h000, g[15], g[12:8]};
    endfunction

    task automatic report_and_stop;
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'h5485));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rchk(BGC_ADDR_MASK, 16'h0140);
        rchk(BGC_ADDR_SCRATCH, 16'h0000);
        rchk(BGC_ADDR_BRIDGE_GENERAL_CONTROL, 16'h0801);
        chk({10'h000, ctl}, exp_ctl(BGC_GEN_RST));
        $display("Test reset values done");
        for (i = 0; i < 8; i++)
        begin
            d = (i == 0) ? 16'hffff : 16'($urandom);
            host.wr(BGC_ADDR_BRIDGE_GENERAL_CONTROL, d);
            rchk(BGC_ADDR_BRIDGE_GENERAL_CONTROL, d & 16'h9fff);
            chk({10'h000, ctl}, exp_ctl(d));
            host.wr(BGC_ADDR_MASK, d);
            rchk(BGC_ADDR_MASK, d & 16'h01ff);
            host.wrrd(BGC_ADDR_SCRATCH, ~d, rb, vb);
            chk({15'h0000, vb}, 16'h0001);
            chk(rb, ~d);
            host.wr(BGC_ADDR_SCRATCH, d);
            rchk(BGC_ADDR_SCRATCH, d);
        end
        host.wr(7'h7f, 16'hffff);
        rchk(7'h7f, 16'h0000);
        $display("Test write and read back done");
        sv = d;
        for (i = 1; i < 4; i++)
        begin
            @(posedge clk);
            mode <= bgc_mode_t'(i);
            host.wr(BGC_ADDR_SCRATCH, ~sv);
            rchk(BGC_ADDR_SCRATCH, 16'h0000);
            @(posedge clk);
            mode <= BGC_MODE_NORMAL;
            rchk(BGC_ADDR_SCRATCH, sv);
        end
        host.wr(BGC_ADDR_MASK, 16'h01aa);
        @(posedge clk);
        restart_reset <= 1'b1;
        @(posedge clk);
        restart_reset <= 1'b0;
        rchk(BGC_ADDR_MASK, 16'h01aa);
        rchk(BGC_ADDR_SCRATCH, sv);
        $display("Test modes and restart done");
        for (i = 0; i < 4; i++)
        begin
            m = i[1:0];
            host.wr(BGC_ADDR_MASK, {14'h0000, m});
            for (e = 2'd1; e != 2'd0; e++)
                repeat (2)
                begin
                    @(posedge clk);
                    evt <= bgc_evt_t'(e);
                    @(posedge clk);
                    evt <= '0;
                    #1;
                    chk({15'h0000, interrupt_out_n}, {15'h0000, ~((e[1] & m[0]) | (e[0] & m[1]))});
                    @(posedge clk);
                    #1;
                    chk({15'h0000, interrupt_out_n}, 16'h0001);
                end
        end
        // Two back to back temperature events give two low cycles
        @(posedge clk);
        evt <= bgc_evt_t'(2'b01);
        @(posedge clk);
        #1;
        chk({15'h0000, interrupt_out_n}, 16'h0000);
        @(posedge clk);
        evt <= '0;
        #1;
        chk({15'h0000, interrupt_out_n}, 16'h0000);
        @(posedge clk);
        #1;
        chk({15'h0000, interrupt_out_n}, 16'h0001);
        rchk(BGC_ADDR_SCRATCH, sv);
        $display("Test interrupt events done");
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        rchk(BGC_ADDR_MASK, 16'h0140);
        rchk(BGC_ADDR_SCRATCH, 16'h0000);
        rchk(BGC_ADDR_BRIDGE_GENERAL_CONTROL, 16'h0801);
        $display("Test soft reset done");
        report_and_stop();
    end
endmodule

`default_nettype wire
